// *** core/sad_adapter.sv ***
// Stream adapter chain: channel, error, timing and width adapters
//
// Behaviour
// - A 128-bit input word leaves as four 32-bit output words, low lane first.
// - An 8-word FIFO buffers beats between the width stage and the sink.
// - The FIFO pop uses the sink ready both directly and after two register stages.
// - A sink without ready ties SNK_READY_I high, and a source must hold SRC_VALID_I until SRC_READY_O is high.
// - The 4-bit source channel field is cut to its low 2 bits on the sink channel.
// - A beat whose channel the sink cannot represent is dropped and flagged.
// - Error bits supported by both sides pass straight to the sink.
// - A source error bit the sink lacks is not forwarded but raises ERR_DROP_O.
// - A sink error bit the source lacks is held at zero.
// - All transfers use the rising clock edge, and all outputs come from flip-flops.
// - Data keeps its meaning and order through every stage.
`timescale 1ns/1ps
`include "sad_defines.svh"
module sad_adapter
  import sad_pkg::*;
(
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic [`SAD_IN_W-1:0] SRC_DATA_I,
  input wire logic [`SAD_SRC_CH_W-1:0] SRC_CHAN_I,
  input wire logic [`SAD_ERR_SRC_W-1:0] SRC_ERR_I,
  input wire logic SRC_VALID_I,
  output logic SRC_READY_O,
  output logic [`SAD_OUT_W-1:0] SNK_DATA_O,
  output logic [`SAD_SNK_CH_W-1:0] SNK_CHAN_O,
  output logic [`SAD_ERR_SNK_W-1:0] SNK_ERR_O,
  output logic SNK_VALID_O,
  input wire logic SNK_READY_I,
  output logic CHAN_DROP_O,
  output logic ERR_DROP_O
);
  localparam int OW = $bits(sad_out_beat_t);

  // ----------------------------------------
  // Width stage: holds one wide word
  // ----------------------------------------
  sad_state_t state_q, state_d;
  sad_in_beat_t word_q, word_d;
  logic [`SAD_LANE_IDX_W-1:0] lane_q, lane_d;
  logic src_ready_q, src_ready_d;
  logic chan_drop_q, chan_drop_d;
  logic err_drop_q, err_drop_d;
  sad_out_beat_t lane_beat;
  logic fifo_in_ready, take, chan_ok;
  logic [`SAD_ERR_SRC_W-1:0] err_unsup;

  always_comb
  begin
    chan_ok = (SRC_CHAN_I >> `SAD_SNK_CH_W) == '0;
    err_unsup = SRC_ERR_I & ~`SAD_ERR_SRC_MAP;
    take = SRC_VALID_I && src_ready_q;
    lane_beat.data = word_q.data[lane_q*`SAD_OUT_W +: `SAD_OUT_W];
    lane_beat.chan = word_q.chan[`SAD_SNK_CH_W-1:0];
    lane_beat.err = `SAD_ERR_SNK_W'(word_q.err & `SAD_ERR_SRC_MAP) & `SAD_ERR_SNK_MAP;
  end

  always_comb
  begin
    state_d = state_q;
    word_d = word_q;
    lane_d = lane_q;
    chan_drop_d = 1'b0;
    err_drop_d = 1'b0;
    unique case (state_q)
      SAD_IDLE:
      begin
        if (take)
        begin
          chan_drop_d = !chan_ok;
          err_drop_d = |err_unsup;
          if (chan_ok)
          begin
            word_d.data = SRC_DATA_I;
            word_d.chan = SRC_CHAN_I;
            word_d.err = SRC_ERR_I;
            lane_d = '0;
            state_d = SAD_SPLIT;
          end
        end
      end
      SAD_SPLIT:
      begin
        if (fifo_in_ready)
        begin
          lane_d = lane_q + 1'b1;
          if (lane_q == `SAD_LANE_IDX_W'(`SAD_LANES - 1))
          begin
            state_d = SAD_IDLE;
          end
        end
      end
    endcase
    src_ready_d = (state_d == SAD_IDLE);
  end

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      state_q <= SAD_IDLE;
      word_q <= '0;
      lane_q <= '0;
      src_ready_q <= 1'b0;
      chan_drop_q <= 1'b0;
      err_drop_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      word_q <= word_d;
      lane_q <= lane_d;
      src_ready_q <= src_ready_d;
      chan_drop_q <= chan_drop_d;
      err_drop_q <= err_drop_d;
    end
  end

  // ----------------------------------------
  // Timing stage: FIFO and ready pipeline
  // ----------------------------------------
  logic [`SAD_PIPE_STAGES-1:0] rdy_pipe_q, rdy_pipe_d;
  logic [OW-1:0] fifo_out;
  logic fifo_valid, fifo_pop;
  sad_out_beat_t out_q, out_d;
  logic out_valid_q, out_valid_d;

  // buffer between width stage and sink
  sad_fifo #(
    .WIDTH(OW),
    .DEPTH(`SAD_FIFO_DEPTH),
    .AW(`SAD_FIFO_AW)
  ) u_fifo (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .in_data_i(lane_beat),
    .in_valid_i(state_q == SAD_SPLIT),
    .in_ready_o(fifo_in_ready),
    .out_data_o(fifo_out),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop)
  );

  always_comb
  begin
    rdy_pipe_d = {rdy_pipe_q[`SAD_PIPE_STAGES-2:0], SNK_READY_I};
    fifo_pop = fifo_valid && (!out_valid_q || (SNK_READY_I && rdy_pipe_q[`SAD_PIPE_STAGES-1]));
    out_d = out_q;
    out_valid_d = out_valid_q;
    if (out_valid_q && SNK_READY_I)
    begin
      out_valid_d = 1'b0;
    end
    if (fifo_pop)
    begin
      out_d = sad_out_beat_t'(fifo_out);
      out_valid_d = 1'b1;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (RST_I)
    begin
      rdy_pipe_q <= '0;
      out_q <= '0;
      out_valid_q <= 1'b0;
    end
    else
    begin
      rdy_pipe_q <= rdy_pipe_d;
      out_q <= out_d;
      out_valid_q <= out_valid_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // all outputs registered
  assign SRC_READY_O = src_ready_q;
  assign SNK_DATA_O = out_q.data;
  assign SNK_CHAN_O = out_q.chan;
  assign SNK_ERR_O = out_q.err;
  assign SNK_VALID_O = out_valid_q;
  assign CHAN_DROP_O = chan_drop_q;
  assign ERR_DROP_O = err_drop_q;
endmodule

// *** common/sad_defines.svh ***
// Constants for the stream adapter chain
`ifndef SAD_DEFINES_SVH
`define SAD_DEFINES_SVH
`define SAD_IN_W 128
`define SAD_OUT_W 32
`define SAD_LANES 4
`define SAD_LANE_IDX_W 2
`define SAD_SRC_CH_W 4
`define SAD_SNK_CH_W 2
`define SAD_ERR_SRC_W 3
`define SAD_ERR_SNK_W 3
`define SAD_ERR_SRC_MAP 3'h3
`define SAD_ERR_SNK_MAP 3'h3
`define SAD_FIFO_DEPTH 8
`define SAD_FIFO_AW 3
`define SAD_PIPE_STAGES 2
`endif

// *** common/sad_pkg.sv ***
// Types for the stream adapter chain
package sad_pkg;
  `include "sad_defines.svh"
  typedef struct packed {
    logic [`SAD_IN_W-1:0] data;
    logic [`SAD_SRC_CH_W-1:0] chan;
    logic [`SAD_ERR_SRC_W-1:0] err;
  } sad_in_beat_t;
  typedef struct packed {
    logic [`SAD_OUT_W-1:0] data;
    logic [`SAD_SNK_CH_W-1:0] chan;
    logic [`SAD_ERR_SNK_W-1:0] err;
  } sad_out_beat_t;
  typedef enum logic [0:0] {
    SAD_IDLE = 1'b0,
    SAD_SPLIT = 1'b1
  } sad_state_t;
endpackage

// *** core/sad_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module sad_fifo
#(
  parameter int WIDTH = 37,
  parameter int DEPTH = 8,
  parameter int AW = 3
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_q, wr_d, rd_q, rd_d;
  logic push, pop;

  always_comb
  begin
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wr_q <= '0;
      rd_q <= '0;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem[wr_q[AW-1:0]] <= in_data_i;
    end
  end

  assign in_ready_o = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
  assign out_valid_o = (wr_q != rd_q);
  assign out_data_o = mem[rd_q[AW-1:0]];
endmodule

// *** test/sad_adapter_assertions.sv ***
// Port checks for the stream adapter
`timescale 1ns/1ps
`include "sad_defines.svh"
module sad_adapter_assertions (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic [`SAD_SRC_CH_W-1:0] SRC_CHAN_I,
  input wire logic [`SAD_ERR_SRC_W-1:0] SRC_ERR_I,
  input wire logic SRC_VALID_I,
  input wire logic SRC_READY_O,
  input wire logic [`SAD_OUT_W-1:0] SNK_DATA_O,
  input wire logic [`SAD_SNK_CH_W-1:0] SNK_CHAN_O,
  input wire logic [`SAD_ERR_SNK_W-1:0] SNK_ERR_O,
  input wire logic SNK_VALID_O,
  input wire logic SNK_READY_I,
  input wire logic CHAN_DROP_O,
  input wire logic ERR_DROP_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  wire logic tk = SRC_VALID_I && SRC_READY_O;
  wire logic bad = SRC_CHAN_I[3:2] != 2'h0;
  property p_tie; SNK_ERR_O[2] == 1'b0; endproperty
  a_tie: assert property (p_tie) else $error("error bit 2 not tied");
  property p_hold; SNK_VALID_O && !SNK_READY_I |=> SNK_VALID_O && $stable(SNK_DATA_O); endproperty
  a_hold: assert property (p_hold) else $error("beat not held");
  property p_side; SNK_VALID_O && !SNK_READY_I |=> $stable({SNK_CHAN_O, SNK_ERR_O}); endproperty
  a_side: assert property (p_side) else $error("side fields moved");
  property p_chd; tk && bad |=> CHAN_DROP_O && SRC_READY_O; endproperty
  a_chd: assert property (p_chd) else $error("bad channel not dropped");
  property p_busy; tk && !bad |=> !SRC_READY_O [*4]; endproperty
  a_busy: assert property (p_busy) else $error("ready back too soon");
  property p_erd; tk && !bad && SRC_ERR_I[2] |=> ERR_DROP_O; endproperty
  a_erd: assert property (p_erd) else $error("error flag missing");
  property p_ern; tk && !SRC_ERR_I[2] |=> !ERR_DROP_O; endproperty
  a_ern: assert property (p_ern) else $error("spurious error flag");
  property p_idle; !tk |=> !CHAN_DROP_O && !ERR_DROP_O; endproperty
  a_idle: assert property (p_idle) else $error("flag without transfer");
  c_chd: cover property (tk && bad);
  c_erd: cover property (tk && SRC_ERR_I[2]);
  c_stall: cover property (SNK_VALID_O && !SNK_READY_I);
endmodule

// *** test/sad_sink_model.sv ***
// Sink ready model: prompt, slow or stopped
`timescale 1ns/1ps
module sad_sink_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] mode_i,
  output logic ready_o
);
  logic ready_q;
  logic ready_d;
  always_comb
  begin
    ready_d = (mode_i == 2'h0) || (mode_i == 2'h1 && !ready_q);
  end
  always_ff @(posedge clk_i)
  begin
    ready_q <= rst_i ? 1'b0 : ready_d;
  end
  assign ready_o = ready_q;
endmodule

// *** test/tb_top.sv ***
// Testbench for the stream adapter
`timescale 1ns/1ps
`include "sad_defines.svh"
module tb_top;
  logic clk = 0, rst = 1, sv = 0;
  logic [127:0] sd = '0;
  logic [3:0] sc = '0;
  logic [2:0] se = '0;
  logic [1:0] mode = 2'h0;
  wire logic rdy, srdy, ov, cd, ed;
  wire logic [31:0] od;
  wire logic [1:0] oc;
  wire logic [2:0] oe;
  int fails = 0, num_checks = 0, cyc = 0;
  sad_pkg::sad_out_beat_t got[$], exp[$];
  always #5 clk = ~clk;
  sad_adapter sad_adapter_inst (.CLK_I(clk), .RST_I(rst), .SRC_DATA_I(sd), .SRC_CHAN_I(sc), .SRC_ERR_I(se),
    .SRC_VALID_I(sv), .SRC_READY_O(rdy), .SNK_DATA_O(od), .SNK_CHAN_O(oc), .SNK_ERR_O(oe),
    .SNK_VALID_O(ov), .SNK_READY_I(srdy), .CHAN_DROP_O(cd), .ERR_DROP_O(ed));
  sad_sink_model sad_sink_model_inst (.clk_i(clk), .rst_i(rst), .mode_i(mode), .ready_o(srdy));
  always @(posedge clk)
  begin
    if (ov && srdy) got.push_back({od, oc, oe});
    cyc++;
    if (cyc == 4000)
    begin
      fails++;
      summarize;
    end
  end
  task check(input logic [36:0] s, input logic [36:0] e);
    num_checks++;
    if (s !== e)
    begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task summarize;
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task send(input logic [127:0] d, input logic [3:0] c, input logic [2:0] e, input bit keep);
    // One edge between requests
    @(posedge clk);
    sd <= d;
    sc <= c;
    se <= e;
    sv <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    sv <= 1'b0;
    if (keep) for (int i = 0; i < 4; i++) exp.push_back({d[32*i+:32], c[1:0], 1'b0, e[1:0]});
  endtask
  task drain(input int n);
    for (int k = 0; k < 300 && got.size() < n; k++) @(posedge clk);
    check(37'(got.size()), 37'(n));
    while (exp.size() > 0 && got.size() > 0) check(got.pop_front(), exp.pop_front());
    got.delete();
    exp.delete();
  endtask
  task t_split;
    send(128'h44444444_33333333_22222222_11111111, 4'h1, 3'h0, 1);
    drain(4);
    $display("split done");
  endtask
  task t_stall;
    mode <= 2'h1;
    send(128'hDDDD0004_CCCC0003_BBBB0002_AAAA0001, 4'h2, 3'h3, 1);
    send(128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210, 4'h3, 3'h1, 1);
    drain(8);
    $display("stall done");
  endtask
  task t_drop;
    mode <= 2'h0;
    send(128'h5, 4'h5, 3'h0, 0);
    #1 check(37'({cd, rdy}), 37'h3);
    send(128'h6, 4'h2, 3'h4, 1);
    #1 check(37'(ed), 37'h1);
    drain(4);
    $display("drop done");
  endtask
  task t_fill;
    mode <= 2'h2;
    for (int w = 1; w < 4; w++) send({4{32'(w)}} + 128'h10, 4'(w), 3'h0, 1);
    repeat (30) @(posedge clk);
    #1 check(37'(rdy), 37'h0);
    @(posedge clk);
    mode <= 2'h1;
    send(128'hF0F0, 4'h0, 3'h2, 1);
    drain(16);
    $display("fill done");
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_split;
    t_stall;
    t_drop;
    t_fill;
    summarize;
  end
endmodule
bind sad_adapter sad_adapter_assertions sad_adapter_assertions_inst (.CLK_I(CLK_I), .RST_I(RST_I),
  .SRC_CHAN_I(SRC_CHAN_I), .SRC_ERR_I(SRC_ERR_I), .SRC_VALID_I(SRC_VALID_I), .SRC_READY_O(SRC_READY_O),
  .SNK_DATA_O(SNK_DATA_O), .SNK_CHAN_O(SNK_CHAN_O), .SNK_ERR_O(SNK_ERR_O), .SNK_VALID_O(SNK_VALID_O),
  .SNK_READY_I(SNK_READY_I), .CHAN_DROP_O(CHAN_DROP_O), .ERR_DROP_O(ERR_DROP_O));
